//--- bcr_cfg.svh
// Register offsets, field positions, reset values and timing constants
`ifndef BCR_CFG_SVH
`define BCR_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BCR_OFS_CTRL        8'h00
`define BCR_OFS_TARGET      8'h01

// ----------------------------------------------------------------
// Field positions of buck_control_config
// ----------------------------------------------------------------
`define BCR_BIT_RSVD        7
`define BCR_BIT_DISCHARGE   6
`define BCR_BIT_RAMP_HI     5
`define BCR_BIT_RAMP_LO     4
`define BCR_BIT_ILIM        3
`define BCR_BIT_MODE        2
`define BCR_BIT_COMBINE     1
`define BCR_BIT_SW_EN       0

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define BCR_RST_ILIM        1'b1
`define BCR_RST_MODE        1'b0
`define BCR_RST_COMBINE     1'b0
`define BCR_RST_SW_EN       1'b0
`define BCR_RST_RSVD        1'b0
`define BCR_LEVEL_MAX       7'h54
`define BCR_ADDR_DEFAULT    7'h1e
`define BCR_LEVEL_DEFAULT   7'h08

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BCR_CLK_HZ          20000000
`define BCR_RAMP_BASE_US    14'h03e8

`endif

//--- bcr_pkg.sv
// Types shared by the configuration bank modules
`default_nettype none

package bcr_pkg;

    // ----------------------------------------------------------------
    // Serial slave states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        BCR_ST_IDLE      = 4'h0,
        BCR_ST_ADDR      = 4'h1,
        BCR_ST_ADDR_ACK  = 4'h3,
        BCR_ST_REG_PTR   = 4'h2,
        BCR_ST_PTR_ACK   = 4'h6,
        BCR_ST_WDATA     = 4'h7,
        BCR_ST_WDATA_ACK = 4'h5,
        BCR_ST_RDATA     = 4'h4,
        BCR_ST_RDATA_ACK = 4'hc
    } bcr_slave_st_t;

    typedef struct packed {
        bcr_slave_st_t st;
        logic [3:0]    bitcnt;
        logic [7:0]    shreg;
        logic [7:0]    ptr;
        logic          rw;
        logic          scl_p;
        logic          sda_p;
        logic          sda_oe_n;
        logic          if_active;
        logic [7:0]    reg_a;
        logic [7:0]    reg_b;
    } bcr_slave_t;

    typedef struct packed {
        logic          run;
        logic          discharge;
        logic [1:0]    ramp_sel;
        logic [13:0]   ramp_us;
        logic          ilim;
        logic          ffm;
        logic [6:0]    level;
    } bcr_ctrl_t;

endpackage : bcr_pkg

`default_nettype wire

//--- bcr_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none

module bcr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] async_i,
    output var  logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule : bcr_sync

`default_nettype wire

//--- bcr_ctrl.sv
// Registered decode of the configuration fields for the power stage
`timescale 1ns/100ps
`default_nettype none
`include "bcr_cfg.svh"

module bcr_ctrl import bcr_pkg::*; #(
    parameter bit EXT_FEEDBACK = 1'b0
) (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic [7:0] reg_a_i,
    input  wire logic [7:0] reg_b_i,
    input  wire logic       enable_pin_i,
    input  wire logic       thermal_shutdown_i,
    output var  bcr_ctrl_t  ctrl_o
);

    bcr_ctrl_t d;

    always_comb begin
        logic en_comb;
        en_comb = 1'b0;
        d       = ctrl_o;
        en_comb = reg_a_i[`BCR_BIT_COMBINE]
                ? (enable_pin_i & reg_a_i[`BCR_BIT_SW_EN])
                : (enable_pin_i | reg_a_i[`BCR_BIT_SW_EN]);
        d.run       = en_comb & ~thermal_shutdown_i;
        d.discharge = reg_a_i[`BCR_BIT_DISCHARGE] & ~EXT_FEEDBACK;
        d.ramp_sel  = reg_a_i[`BCR_BIT_RAMP_HI:`BCR_BIT_RAMP_LO];
        d.ramp_us   = 14'(`BCR_RAMP_BASE_US << d.ramp_sel);
        d.ilim      = reg_a_i[`BCR_BIT_ILIM];
        d.ffm       = reg_a_i[`BCR_BIT_MODE];
        if (EXT_FEEDBACK) begin
            d.level = 7'h00;
        end else if (reg_b_i[6:0] >= `BCR_LEVEL_MAX) begin
            d.level = `BCR_LEVEL_MAX;
        end else begin
            d.level = reg_b_i[6:0];
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_o <= '0;
        end else begin
            ctrl_o <= d;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_level_sat;
        @(posedge clk_i) disable iff (reset_i)
        ctrl_o.level <= `BCR_LEVEL_MAX;
    endproperty
    a_level_sat: assert property (p_level_sat) else $error("level above ceiling");

    property p_run_or;
        @(posedge clk_i) disable iff (reset_i)
        (!reg_a_i[`BCR_BIT_COMBINE] && reg_a_i[`BCR_BIT_SW_EN] && !thermal_shutdown_i)
            |=> ctrl_o.run;
    endproperty
    a_run_or: assert property (p_run_or) else $error("or enable failed");

    property p_run_and;
        @(posedge clk_i) disable iff (reset_i)
        (reg_a_i[`BCR_BIT_COMBINE] && !reg_a_i[`BCR_BIT_SW_EN]) |=> !ctrl_o.run;
    endproperty
    a_run_and: assert property (p_run_and) else $error("and enable failed");

    property p_thermal;
        @(posedge clk_i) disable iff (reset_i)
        thermal_shutdown_i |=> !ctrl_o.run;
    endproperty
    a_thermal: assert property (p_thermal) else $error("ran while hot");

    property p_mode;
        @(posedge clk_i) disable iff (reset_i)
        $rose(reg_a_i[`BCR_BIT_MODE]) |=> ctrl_o.ffm;
    endproperty
    a_mode: assert property (p_mode) else $error("mode change not applied");

endmodule : bcr_ctrl

`default_nettype wire

//--- bcr_top.sv
// Buck configuration register bank behind a two-wire serial slave
//
// Notes on behaviour
// - Answer only the one strapped 7-bit address.
// - Bit 7 of both registers does nothing.
// - Discharge flag drives discharge, off for external.
// - Ramp select maps to 1/2/4/8 ms.
// - Current limit bit selects 500/2000 mA, resets 1.
// - Mode bit picks skip or fixed-frequency, resets 0.
// - Pin and software enable ORed or ANDed.
// - Enable bit and combine bit reset to 0.
// - Level code saturates from 0x54 upward, zero for external.
// - Level resets to preset, writes apply at once.
// - Converter runs when enabled, supply valid, cool.
// - Mode change accepted and applied while running.
// - Undervoltage reset returns all fields to defaults.
// - Byte registers, bursts auto-increment the pointer.
// - Other addresses are never acknowledged.
// - Interface active on interface power or pin.
// - Serial clock from static up to 3.4 MHz.
`timescale 1ns/100ps
`default_nettype none
`include "bcr_cfg.svh"

module bcr_top import bcr_pkg::*; #(
    parameter logic [6:0] SLAVE_ADDR    = `BCR_ADDR_DEFAULT,
    parameter bit         EXT_FEEDBACK  = 1'b0,
    parameter logic [6:0] LEVEL_RESET   = `BCR_LEVEL_DEFAULT,
    parameter logic [1:0] RAMP_RESET    = 2'h0,
    parameter logic       DISCH_RESET   = 1'b1
) (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output var  logic        sda_o,
    output var  logic        sda_oe_n_o,
    input  wire logic        enable_pin_i,
    input  wire logic        interface_power_enable_i,
    input  wire logic        thermal_shutdown_i,
    output var  logic        interface_active_o,
    output var  logic        converter_run_o,
    output var  logic        discharge_enable_o,
    output var  logic [1:0]  ramp_time_select_o,
    output var  logic [13:0] ramp_time_us_o,
    output var  logic        current_limit_select_o,
    output var  logic        forced_fixed_frequency_o,
    output var  logic [6:0]  output_level_code_o
);

    // ----------------------------------------------------------------
    // Reset image
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = {`BCR_RST_RSVD, DISCH_RESET, RAMP_RESET,
                                         `BCR_RST_ILIM, `BCR_RST_MODE,
                                         `BCR_RST_COMBINE, `BCR_RST_SW_EN};
    localparam bcr_slave_t SLAVE_RESET = '{
        st:        BCR_ST_IDLE,
        bitcnt:    4'h0,
        shreg:     8'h00,
        ptr:       8'h00,
        rw:        1'b0,
        scl_p:     1'b1,
        sda_p:     1'b1,
        sda_oe_n:  1'b1,
        if_active: 1'b0,
        reg_a:     CTRL_RESET,
        reg_b:     {`BCR_RST_RSVD, LEVEL_RESET}
    };

    function automatic logic [7:0] rd_byte(input logic [7:0] ptr,
                                           input logic [7:0] a,
                                           input logic [7:0] b);
        if (ptr == `BCR_OFS_CTRL) begin
            return a;
        end else if (ptr == `BCR_OFS_TARGET) begin
            return b;
        end
        return 8'h00;
    endfunction : rd_byte

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [4:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       pin_s;
    logic       ipe_s;
    logic       therm_s;

    bcr_sync #(.WIDTH(5)) u_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .async_i ({scl_i, sda_i, enable_pin_i, interface_power_enable_i,
                   thermal_shutdown_i}),
        .sync_o  (pins_s)
    );

    assign {scl_s, sda_s, pin_s, ipe_s, therm_s} = pins_s;

    // ----------------------------------------------------------------
    // Serial slave and registers
    // ----------------------------------------------------------------
    bcr_slave_t q;
    bcr_slave_t d;
    logic       active;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;

    assign active = pin_s | ipe_s;
    assign rise   = scl_s & ~q.scl_p;
    assign fall   = ~scl_s & q.scl_p;
    assign start  = scl_s & q.scl_p & q.sda_p & ~sda_s;
    assign stop   = scl_s & q.scl_p & ~q.sda_p & sda_s;

    always_comb begin
        logic [7:0] rd;
        rd          = rd_byte(q.ptr, q.reg_a, q.reg_b);
        d           = q;
        d.scl_p     = scl_s;
        d.sda_p     = sda_s;
        d.if_active = active;
        if (!active) begin
            d.st       = BCR_ST_IDLE;
            d.sda_oe_n = 1'b1;
        end else if (start) begin
            d.st       = BCR_ST_ADDR;
            d.bitcnt   = 4'h0;
            d.sda_oe_n = 1'b1;
        end else if (stop) begin
            d.st       = BCR_ST_IDLE;
            d.sda_oe_n = 1'b1;
        end else if (rise) begin
            if (q.st == BCR_ST_ADDR || q.st == BCR_ST_REG_PTR || q.st == BCR_ST_WDATA) begin
                d.shreg  = {q.shreg[6:0], sda_s};
                d.bitcnt = 4'(q.bitcnt + 4'h1);
            end else if (q.st == BCR_ST_RDATA) begin
                d.bitcnt = 4'(q.bitcnt + 4'h1);
            end else if (q.st == BCR_ST_RDATA_ACK && sda_s) begin
                d.st = BCR_ST_IDLE;                             // Master ends burst
            end
        end else if (fall) begin
            unique case (q.st)
                BCR_ST_IDLE: begin
                end
                BCR_ST_ADDR: begin
                    if (q.bitcnt == 4'h8) begin
                        if (q.shreg[7:1] == SLAVE_ADDR) begin
                            d.sda_oe_n = 1'b0;
                            d.rw       = q.shreg[0];
                            d.st       = BCR_ST_ADDR_ACK;
                        end else begin
                            d.st = BCR_ST_IDLE;
                        end
                    end
                end
                BCR_ST_ADDR_ACK: begin
                    d.bitcnt = 4'h0;
                    if (q.rw) begin
                        d.shreg    = rd;
                        d.sda_oe_n = rd[7];
                        d.st       = BCR_ST_RDATA;
                    end else begin
                        d.sda_oe_n = 1'b1;
                        d.st       = BCR_ST_REG_PTR;
                    end
                end
                BCR_ST_REG_PTR: begin
                    if (q.bitcnt == 4'h8) begin
                        d.ptr      = q.shreg;
                        d.sda_oe_n = 1'b0;
                        d.st       = BCR_ST_PTR_ACK;
                    end
                end
                BCR_ST_PTR_ACK, BCR_ST_WDATA_ACK: begin
                    d.sda_oe_n = 1'b1;
                    d.bitcnt   = 4'h0;
                    d.st       = BCR_ST_WDATA;
                end
                BCR_ST_WDATA: begin
                    if (q.bitcnt == 4'h8) begin
                        if (q.ptr == `BCR_OFS_CTRL) begin
                            d.reg_a = q.shreg;
                        end else if (q.ptr == `BCR_OFS_TARGET) begin
                            d.reg_b = q.shreg;
                        end
                        d.ptr      = 8'(q.ptr + 8'h01);
                        d.sda_oe_n = 1'b0;
                        d.st       = BCR_ST_WDATA_ACK;
                    end
                end
                BCR_ST_RDATA: begin
                    if (q.bitcnt == 4'h8) begin
                        d.sda_oe_n = 1'b1;
                        d.ptr      = 8'(q.ptr + 8'h01);
                        d.st       = BCR_ST_RDATA_ACK;
                    end else begin
                        d.shreg    = {q.shreg[6:0], 1'b0};
                        d.sda_oe_n = q.shreg[6];
                    end
                end
                BCR_ST_RDATA_ACK: begin
                    d.bitcnt   = 4'h0;
                    d.shreg    = rd;
                    d.sda_oe_n = rd[7];
                    d.st       = BCR_ST_RDATA;
                end
                default: begin
                    d.st       = BCR_ST_IDLE;
                    d.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    // Undervoltage lockout arrives as reset_i
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            q <= SLAVE_RESET;
        end else begin
            q <= d;
        end
    end

    assign sda_o              = 1'b0;
    assign sda_oe_n_o         = q.sda_oe_n;
    assign interface_active_o = q.if_active;

    // ----------------------------------------------------------------
    // Power stage controls
    // ----------------------------------------------------------------
    bcr_ctrl_t ctrl;

    bcr_ctrl #(.EXT_FEEDBACK(EXT_FEEDBACK)) u_ctrl (
        .clk_i              (clk_i),
        .reset_i            (reset_i),
        .reg_a_i            (q.reg_a),
        .reg_b_i            (q.reg_b),
        .enable_pin_i       (pin_s),
        .thermal_shutdown_i (therm_s),
        .ctrl_o             (ctrl)
    );

    assign converter_run_o          = ctrl.run;
    assign discharge_enable_o       = ctrl.discharge;
    assign ramp_time_select_o       = ctrl.ramp_sel;
    assign ramp_time_us_o           = ctrl.ramp_us;
    assign current_limit_select_o   = ctrl.ilim;
    assign forced_fixed_frequency_o = ctrl.ffm;
    assign output_level_code_o      = ctrl.level;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic byte_end;
    assign byte_end = active & ~start & ~stop & fall & (q.bitcnt == 4'h8);

    property p_addr_ack;
        @(posedge clk_i) disable iff (reset_i)
        (byte_end && q.st == BCR_ST_ADDR && q.shreg[7:1] == SLAVE_ADDR)
            |=> (!sda_oe_n_o && q.st == BCR_ST_ADDR_ACK);
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");

    property p_addr_nack;
        @(posedge clk_i) disable iff (reset_i)
        (byte_end && q.st == BCR_ST_ADDR && q.shreg[7:1] != SLAVE_ADDR)
            |=> (sda_oe_n_o && q.st == BCR_ST_IDLE);
    endproperty
    a_addr_nack: assert property (p_addr_nack) else $error("foreign address acked");

    property p_ptr_inc;
        @(posedge clk_i) disable iff (reset_i)
        (byte_end && q.st == BCR_ST_WDATA) |=> (q.ptr == 8'($past(q.ptr) + 8'h01));
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not advance");

    property p_level_write;
        @(posedge clk_i) disable iff (reset_i)
        (byte_end && q.st == BCR_ST_WDATA && q.ptr == `BCR_OFS_TARGET)
            |=> (q.reg_b == $past(q.shreg)) ##2 (EXT_FEEDBACK ||
                output_level_code_o == ((q.reg_b[6:0] >= `BCR_LEVEL_MAX)
                                        ? `BCR_LEVEL_MAX : q.reg_b[6:0]));
    endproperty
    a_level_write: assert property (p_level_write) else $error("level write lost");

    property p_inactive;
        @(posedge clk_i) disable iff (reset_i)
        !active |=> (q.st == BCR_ST_IDLE && sda_oe_n_o);
    endproperty
    a_inactive: assert property (p_inactive) else $error("slave busy while off");

    property p_cov_write;
        @(posedge clk_i) disable iff (reset_i)
        byte_end && q.st == BCR_ST_WDATA;
    endproperty
    c_cov_write: cover property (p_cov_write);

    property p_cov_read;
        @(posedge clk_i) disable iff (reset_i)
        q.st == BCR_ST_RDATA_ACK ##1 q.st == BCR_ST_RDATA;
    endproperty
    c_cov_read: cover property (p_cov_read);

    property p_cov_nack;
        @(posedge clk_i) disable iff (reset_i)
        byte_end && q.st == BCR_ST_ADDR && q.shreg[7:1] != SLAVE_ADDR;
    endproperty
    c_cov_nack: cover property (p_cov_nack);

endmodule : bcr_top

`default_nettype wire

//--- bcr_host_model.sv
// Serial bus master model that configures the bank over SCL and SDA
`timescale 1ns/100ps
`default_nettype none

module bcr_host_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_o
);
    // ----------------------------------------------------------------
    // Bit timing: 4 clocks low, 4 high, 2.5 MHz serial clock
    // ----------------------------------------------------------------
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic gap(input int n);
        repeat (n) @(posedge clk_i);
    endtask : gap

    task automatic start();
        gap(1);
        sda_o <= 1'b1;
        gap(3);
        scl_o <= 1'b1;
        gap(3);
        sda_o <= 1'b0;
        gap(3);
        scl_o <= 1'b0;
    endtask : start

    task automatic stop();
        gap(1);
        sda_o <= 1'b0;
        gap(3);
        scl_o <= 1'b1;
        gap(3);
        sda_o <= 1'b1;
        gap(4);
    endtask : stop

    task automatic bit_xfer(input logic b, output logic s);
        gap(1);
        sda_o <= b;
        gap(3);
        scl_o <= 1'b1;
        gap(2);
        s = sda_i;
        gap(2);
        scl_o <= 1'b0;
    endtask : bit_xfer

    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], s);
        end
        bit_xfer(1'b1, s);
        ack = ~s;
    endtask : send

    task automatic recv(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, s);
            d[i] = s;
        end
        bit_xfer(~more, s);
    endtask : recv
endmodule : bcr_host_model
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the configuration bank
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    localparam logic [6:0] LVL_RST = 7'h14;
    localparam logic [1:0] RMP_RST = 2'h1;
    localparam logic       DIS_RST = 1'b0;
    localparam logic [7:0] A_RST   = {1'b0, DIS_RST, RMP_RST, 4'h8};
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        pin = 1'b0;
    logic        pwr = 1'b1;
    logic        hot = 1'b0;
    logic        scl, hsda, sda_o, oe_n, act, run, dis, ilim, ffm, oe2_n, dis2;
    logic [1:0]  rmp;
    logic [13:0] rus;
    logic [6:0]  lvl, lvl2;
    logic [7:0]  q0, q1;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cyc = 0;
    wire         sda = hsda & (oe_n | sda_o) & oe2_n;

    always #25 clk_i = ~clk_i;

    bcr_top #(.LEVEL_RESET(LVL_RST), .RAMP_RESET(RMP_RST), .DISCH_RESET(DIS_RST)) bcr_top_inst (
        .clk_i(clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n_o(oe_n), .enable_pin_i(pin), .interface_power_enable_i(pwr),
        .thermal_shutdown_i(hot), .interface_active_o(act), .converter_run_o(run),
        .discharge_enable_o(dis), .ramp_time_select_o(rmp), .ramp_time_us_o(rus),
        .current_limit_select_o(ilim), .forced_fixed_frequency_o(ffm),
        .output_level_code_o(lvl));

    bcr_top #(.SLAVE_ADDR(7'h77), .EXT_FEEDBACK(1'b1)) bcr_top_ext_inst (
        .clk_i(clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe_n_o(oe2_n), .enable_pin_i(pin), .interface_power_enable_i(pwr),
        .thermal_shutdown_i(hot), .interface_active_o(), .converter_run_o(),
        .discharge_enable_o(dis2), .ramp_time_select_o(), .ramp_time_us_o(),
        .current_limit_select_o(), .forced_fixed_frequency_o(),
        .output_level_code_o(lvl2));

    bcr_host_model bcr_host_model_inst (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(hsda));

    task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic addr(input logic [7:0] a, input logic exp);
        logic k;
        bcr_host_model_inst.start();
        bcr_host_model_inst.send(a, k);
        chk("address ack", exp, k);
    endtask : addr

    task automatic wr(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1, input int n);
        logic k;
        addr(8'h3c, 1'b1);
        bcr_host_model_inst.send(p, k);
        bcr_host_model_inst.send(d0, k);
        if (n > 1) bcr_host_model_inst.send(d1, k);
        chk("write ack", 1'b1, k);
        bcr_host_model_inst.stop();
        repeat (4) @(posedge clk_i);
    endtask : wr

    task automatic rd(input logic [7:0] p);
        logic k;
        addr(8'h3c, 1'b1);
        bcr_host_model_inst.send(p, k);
        chk("pointer ack", 1'b1, k);
        addr(8'h3d, 1'b1);
        bcr_host_model_inst.recv(1'b1, q0);
        bcr_host_model_inst.recv(1'b0, q1);
        bcr_host_model_inst.stop();
    endtask : rd

    task automatic chk_rst();
        rd(8'h00);
        chk("reg 0", A_RST, q0);
        chk("reg 1", {1'b0, LVL_RST}, q1);
        chk("limit", 1'b1, ilim);
        chk("mode", 1'b0, ffm);
        chk("discharge", DIS_RST, dis);
        chk("ramp", RMP_RST, rmp);
        chk("level", LVL_RST, lvl);
    endtask : chk_rst

    task automatic t_addr();
        logic [6:0] bad [4] = '{7'h24, 7'h37, 7'h1d, 7'h1f};
        foreach (bad[i]) begin
            addr({bad[i], 1'b0}, 1'b0);
            bcr_host_model_inst.stop();
        end
        $display("test address done");
    endtask : t_addr

    task automatic t_burst();
        wr(8'h00, 8'h8c, 8'hd3, 2); // converter off meanwhile
        rd(8'h00);
        chk("burst 0", 8'h8c, q0);
        chk("burst 1", 8'hd3, q1);
        chk("level", 7'h53, lvl);
        chk("mode", 1'b1, ffm);
        chk("discharge", 1'b0, dis);
        wr(8'h01, 8'h54, 8'h00, 1);
        chk("level", 7'h54, lvl);
        wr(8'h01, 8'h7f, 8'h00, 1);
        chk("level", 7'h54, lvl);
        wr(8'h00, 8'h40, 8'h00, 1);
        chk("discharge", 1'b1, dis);
        chk("limit", 1'b0, ilim);
        rd(8'h01);
        chk("reg 1", 8'h7f, q0);
        chk("past end", 8'h00, q1);
        $display("test burst done");
    endtask : t_burst

    task automatic t_ext();
        logic k;
        addr(8'hee, 1'b1);
        bcr_host_model_inst.send(8'h00, k);
        bcr_host_model_inst.send(8'h40, k);
        bcr_host_model_inst.send(8'h32, k);
        chk("ext ack", 1'b1, k);
        bcr_host_model_inst.stop();
        repeat (4) @(posedge clk_i);
        chk("ext discharge", 1'b0, dis2);
        chk("ext level", 7'h00, lvl2);
        $display("test external feedback done");
    endtask : t_ext

    task automatic t_ramp();
        for (int s = 0; s < 4; s++) begin
            wr(8'h00, {2'b00, s[1:0], 4'h8}, 8'h00, 1);
            chk("ramp", s[1:0], rmp);
            chk("ramp us", 14'h03e8 << s, rus);
        end
        $display("test ramp done");
    endtask : t_ramp

    task automatic t_enable();
        logic e;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            pin <= i[1];
            wr(8'h00, {6'h02, i[2], i[0]}, 8'h00, 1);
            e = i[2] ? (i[1] & i[0]) : (i[1] | i[0]);
            chk("run", e, run);
        end
        wr(8'h00, 8'h0d, 8'h00, 1);
        chk("mode live", 1'b1, ffm);
        chk("run live", 1'b1, run);
        @(posedge clk_i);
        hot <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk("run hot", 1'b0, run);
        hot <= 1'b0;
        pwr <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("run pin", 1'b1, run);
        chk("active pin", 1'b1, act);
        wr(8'h00, 8'h08, 8'h00, 1);
        pin <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("active off", 1'b0, act);
        addr(8'h3c, 1'b0);
        bcr_host_model_inst.stop();
        pwr <= 1'b1;
        repeat (6) @(posedge clk_i);
        $display("test enable done");
    endtask : t_enable

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("active", 1'b1, act);
        chk_rst();
        $display("test reset done");
        t_addr();
        t_burst();
        t_ext();
        t_ramp();
        t_enable();
        reset_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk_rst();
        $display("test undervoltage done");
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
